// File: mtt_pkg.sv
`default_nettype none
package mtt_pkg;

  // ----------------------------------------------------------------------
  // register byte addresses on the apb port
  // ----------------------------------------------------------------------
  localparam logic [7:0] MTT_OFF_CONTROL   = 8'h00;
  localparam logic [7:0] MTT_OFF_VIEW_SEL  = 8'h04;
  localparam logic [7:0] MTT_OFF_CNT_LOW   = 8'h08;
  localparam logic [7:0] MTT_OFF_CNT_HIGH  = 8'h0c;
  localparam logic [7:0] MTT_OFF_WRAP_B0   = 8'h10;
  localparam logic [7:0] MTT_OFF_WRAP_B1   = 8'h14;
  localparam logic [7:0] MTT_OFF_WRAP_B2   = 8'h18;
  localparam logic [7:0] MTT_OFF_FLAGS     = 8'h1c;
  localparam logic [7:0] MTT_OFF_ENABLES   = 8'h20;
  localparam logic [7:0] MTT_OFF_EVT_ROUTE = 8'h24;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int MTT_CTL_GO       = 0;
  localparam int MTT_CTL_EDGE     = 1;
  localparam int MTT_CTL_STATE    = 2;
  localparam int MTT_CTL_SCOPE    = 3;
  localparam int MTT_VIEW_CNT_LSB = 0;
  localparam int MTT_VIEW_WRP_LSB = 4;
  localparam int MTT_ROUTE_A_LSB  = 0;
  localparam int MTT_ROUTE_B_LSB  = 4;
  localparam int MTT_EV_PER       = 0;
  localparam int MTT_EV_CMP_A     = 1;
  localparam int MTT_EV_CMP_B     = 2;
  localparam int MTT_EV_WPER      = 3;
  localparam int MTT_EV_WCMP_A    = 4;
  localparam int MTT_EV_WCMP_B    = 5;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic RST_GO   = 1'b0;
  localparam logic RST_EDGE = 1'b1;

  // ----------------------------------------------------------------------
  // window views and event route codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] VIEW_COUNT   = 3'h0;
  localparam logic [2:0] VIEW_CAPTURE = 3'h1;
  localparam logic [2:0] VIEW_PERIOD  = 3'h2;
  localparam logic [2:0] VIEW_CMP_A   = 3'h3;
  localparam logic [2:0] VIEW_CMP_B   = 3'h4;
  localparam logic [2:0] ROUTE_NONE   = 3'h7;

  // ----------------------------------------------------------------------
  // aligned start arithmetic
  // ----------------------------------------------------------------------
  localparam logic [6:0]  START_CYCLES  = 7'd86;
  localparam logic [39:0] START_OVERHEAD = 40'd86;
  localparam logic [14:0] RATIO_NUM     = 15'd15625;  // 976.5625 * 16
  localparam logic [39:0] RATIO_ROUND   = 40'd8;      // half of 16
  localparam int          RATIO_SHIFT   = 4;
  localparam logic [6:0]  DIV_STEPS     = 7'd40;
  localparam logic [6:0]  DIV2_FIRST    = 7'd42;
  localparam logic [6:0]  DIV2_LAST     = 7'd81;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_EDGE,
    ST_CALC,
    ST_RUN
  } mtt_state_t;

endpackage : mtt_pkg
`default_nettype wire

// File: mtt_timer.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module mtt_timer (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [23:0] sleepTimerValue,
  input  wire logic        slowClkRise,
  input  wire logic        sfdStatus,
  output logic             irqReq,
  output logic             eventOutA,
  output logic             eventOutB
);
  import mtt_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  mtt_state_t  state_r;
  logic        go_r, edgeAligned_r, scope_r;
  logic [2:0]  cntView_r, wrapView_r, routeA_r, routeB_r;
  logic [5:0]  flags_r, enables_r;
  logic [15:0] cnt_r, cntPer_r, cntCmpA_r, cntCmpB_r, cntCap_r, delta_r;
  logic [23:0] wrap_r, wrapPer_r, wrapCmpA_r, wrapCmpB_r, wrapCap_r;
  logic [7:0]  cntStage_r, cntHiLatch_r;
  logic [15:0] wrapStage_r, wrapHiLatch_r;
  logic [7:0]  wrapLoLatch_r;
  logic [23:0] storedSleep_r;
  logic        sfdPrev_r;
  logic [6:0]  calcCnt_r;
  logic [39:0] divQ_r, divR_r, divisor_r;
  logic [15:0] newCnt_r;
  logic [23:0] newWrap_r;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic wrEn, rdEn, setup;
  assign setup = psel & ~penable;
  assign wrEn  = psel & penable & pready & pwrite;
  assign rdEn  = psel & penable & pready & ~pwrite;

  logic wrCtl, wrView, wrCntLo, wrCntHi, wrWrp0, wrWrp1, wrWrp2;
  logic wrFlags, wrEn_m, wrRoute, rdCntLo, rdWrp0;
  assign wrCtl   = wrEn && paddr == MTT_OFF_CONTROL;
  assign wrView  = wrEn && paddr == MTT_OFF_VIEW_SEL;
  assign wrCntLo = wrEn && paddr == MTT_OFF_CNT_LOW;
  assign wrCntHi = wrEn && paddr == MTT_OFF_CNT_HIGH;
  assign wrWrp0  = wrEn && paddr == MTT_OFF_WRAP_B0;
  assign wrWrp1  = wrEn && paddr == MTT_OFF_WRAP_B1;
  assign wrWrp2  = wrEn && paddr == MTT_OFF_WRAP_B2;
  assign wrFlags = wrEn && paddr == MTT_OFF_FLAGS;
  assign wrEn_m  = wrEn && paddr == MTT_OFF_ENABLES;
  assign wrRoute = wrEn && paddr == MTT_OFF_EVT_ROUTE;
  assign rdCntLo = rdEn && paddr == MTT_OFF_CNT_LOW
                   && cntView_r == VIEW_COUNT;
  assign rdWrp0  = rdEn && paddr == MTT_OFF_WRAP_B0
                   && wrapView_r == VIEW_COUNT;

  // full values that a high byte write commits
  logic [15:0] cntWrVal;
  logic [23:0] wrapWrVal;
  assign cntWrVal  = {pwdata[7:0], cntStage_r};
  assign wrapWrVal = {pwdata[7:0], wrapStage_r};

  // ----------------------------------------------------------------------
  // counting and event detection
  // ----------------------------------------------------------------------
  logic        counting, perHit, wperHit;
  logic [15:0] cntInc;
  logic [23:0] wrapInc;
  logic [5:0]  events;
  logic        calcDone;
  assign counting = state_r == ST_RUN && delta_r == 16'h0000;
  assign cntInc   = cnt_r + 16'h0001;
  assign wrapInc  = wrap_r + 24'h000001;
  assign perHit   = counting && cntInc == cntPer_r;
  assign wperHit  = perHit && wrapInc == wrapPer_r;
  assign calcDone = state_r == ST_CALC
                    && calcCnt_r == START_CYCLES - 7'd1;
  always_comb begin
    events = 6'h00;
    events[MTT_EV_PER]    = perHit;
    events[MTT_EV_CMP_A]  = counting && cntInc == cntCmpA_r;
    events[MTT_EV_CMP_B]  = counting && cntInc == cntCmpB_r;
    events[MTT_EV_WPER]   = wperHit;
    events[MTT_EV_WCMP_A] = perHit && wrapInc == wrapCmpA_r;
    events[MTT_EV_WCMP_B] = perHit && wrapInc == wrapCmpB_r;
  end

  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  // go bit and mode bits; go reads back as written, not as state
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      go_r          <= RST_GO;
      edgeAligned_r <= RST_EDGE;
      scope_r       <= 1'b0;
    end else if (wrCtl) begin
      go_r          <= pwdata[MTT_CTL_GO];
      edgeAligned_r <= pwdata[MTT_CTL_EDGE];
      scope_r       <= pwdata[MTT_CTL_SCOPE];
    end
  end

  // mode machine; an aligned stop keeps counting until the slow edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (go_r && !edgeAligned_r) begin
            state_r <= ST_RUN;
          end else if (go_r) begin
            state_r <= ST_WAIT_EDGE;
          end
        end
        ST_WAIT_EDGE: begin
          if (!go_r) begin
            state_r <= ST_IDLE;
          end else if (slowClkRise) begin
            state_r <= ST_CALC;
          end
        end
        ST_CALC: begin
          if (calcDone) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!go_r && (!edgeAligned_r || slowClkRise)) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // sleep timer value kept at an aligned stop for the next start
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      storedSleep_r <= 24'h000000;
    end else if (state_r == ST_RUN && !go_r && edgeAligned_r
                 && slowClkRise) begin
      storedSleep_r <= sleepTimerValue;
    end
  end

  // ----------------------------------------------------------------------
  // aligned start recompute: two 40 step divisions inside 86 cycles
  // ----------------------------------------------------------------------
  logic [23:0] sleepDiff;
  logic [24:0] ticks;
  logic [39:0] scaled, cStart, divTry, divRem, cntDivisor, wrapDivisor;
  logic        divFits;
  assign sleepDiff = sleepTimerValue - storedSleep_r;
  // a zero difference means a full sleep timer turn
  assign ticks  = (sleepDiff == 24'h000000) ? {1'b1, 24'h000000}
                                            : {1'b0, sleepDiff};
  assign scaled = (40'(ticks) * 40'(RATIO_NUM) + RATIO_ROUND) >> RATIO_SHIFT;
  assign cStart = scaled + 40'(cnt_r) + START_OVERHEAD;
  // a zero period means the natural 2^16 or 2^24 turn
  assign cntDivisor  = (cntPer_r == 16'h0000) ? 40'h0000010000
                                              : 40'(cntPer_r);
  assign wrapDivisor = (wrapPer_r == 24'h000000) ? 40'h0001000000
                                                 : 40'(wrapPer_r);
  assign divTry  = {divR_r[38:0], divQ_r[39]};
  assign divFits = divTry >= divisor_r;
  assign divRem  = divFits ? divTry - divisor_r : divTry;

  // step counter for the start sequence
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      calcCnt_r <= 7'd0;
    end else if (state_r == ST_CALC) begin
      calcCnt_r <= calcCnt_r + 7'd1;
    end else begin
      calcCnt_r <= 7'd0;
    end
  end

  // shared restoring divider: first by period, then by wrap period
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      divQ_r    <= 40'h0;
      divR_r    <= 40'h0;
      divisor_r <= 40'h0;
      newCnt_r  <= 16'h0000;
      newWrap_r <= 24'h000000;
    end else if (state_r == ST_WAIT_EDGE && slowClkRise) begin
      divQ_r    <= cStart;
      divR_r    <= 40'h0;
      divisor_r <= cntDivisor;
    end else if (state_r == ST_CALC) begin
      if (calcCnt_r < DIV_STEPS
          || (calcCnt_r >= DIV2_FIRST && calcCnt_r <= DIV2_LAST)) begin
        divQ_r <= {divQ_r[38:0], divFits};
        divR_r <= divRem;
      end else if (calcCnt_r == DIV_STEPS) begin
        newCnt_r  <= divR_r[15:0];
        divQ_r    <= divQ_r + 40'(wrap_r);
        divR_r    <= 40'h0;
        divisor_r <= wrapDivisor;
      end else if (calcCnt_r == DIV2_LAST + 7'd1) begin
        newWrap_r <= divR_r[23:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // counter, delta and wrap counter
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
    end else if (calcDone) begin
      cnt_r <= newCnt_r;
    end else if (wrCntHi && cntView_r == VIEW_COUNT
                 && state_r == ST_IDLE) begin
      cnt_r <= cntWrVal;
    end else if (perHit) begin
      cnt_r <= 16'h0000;
    end else if (counting) begin
      cnt_r <= cntInc;
    end
  end

  // delta holds the counter; it only restarts on a new write
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      delta_r <= 16'h0000;
    end else if (wrCntHi && cntView_r == VIEW_COUNT
                 && state_r == ST_RUN) begin
      delta_r <= cntWrVal;
    end else if (state_r != ST_RUN) begin
      delta_r <= 16'h0000;
    end else if (delta_r != 16'h0000) begin
      delta_r <= delta_r - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrap_r <= 24'h000000;
    end else if (calcDone) begin
      wrap_r <= newWrap_r;
    end else if (wrWrp2 && wrapView_r == VIEW_COUNT) begin
      wrap_r <= wrapWrVal;
    end else if (wperHit) begin
      wrap_r <= 24'h000000;
    end else if (perHit) begin
      wrap_r <= wrapInc;
    end
  end

  // ----------------------------------------------------------------------
  // window settings: period, compares, staging bytes
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cntStage_r  <= 8'h00;
      wrapStage_r <= 16'h0000;
      cntPer_r    <= 16'h0000;
      cntCmpA_r   <= 16'h0000;
      cntCmpB_r   <= 16'h0000;
      wrapPer_r   <= 24'h000000;
      wrapCmpA_r  <= 24'h000000;
      wrapCmpB_r  <= 24'h000000;
    end else begin
      if (wrCntLo) begin
        cntStage_r <= pwdata[7:0];
      end
      if (wrWrp0) begin
        wrapStage_r[7:0] <= pwdata[7:0];
      end
      if (wrWrp1) begin
        wrapStage_r[15:8] <= pwdata[7:0];
      end
      if (wrCntHi) begin
        case (cntView_r)
          VIEW_PERIOD: cntPer_r  <= cntWrVal;
          VIEW_CMP_A:  cntCmpA_r <= cntWrVal;
          VIEW_CMP_B:  cntCmpB_r <= cntWrVal;
          default: ;
        endcase
      end
      if (wrWrp2) begin
        case (wrapView_r)
          VIEW_PERIOD: wrapPer_r  <= wrapWrVal;
          VIEW_CMP_A:  wrapCmpA_r <= wrapWrVal;
          VIEW_CMP_B:  wrapCmpB_r <= wrapWrVal;
          default: ;
        endcase
      end
    end
  end

  // view, routing and enable settings
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cntView_r  <= VIEW_COUNT;
      wrapView_r <= VIEW_COUNT;
      routeA_r   <= 3'h0;
      routeB_r   <= 3'h0;
      enables_r  <= 6'h00;
    end else begin
      if (wrView) begin
        cntView_r  <= pwdata[MTT_VIEW_CNT_LSB +: 3];
        wrapView_r <= pwdata[MTT_VIEW_WRP_LSB +: 3];
      end
      if (wrRoute) begin
        routeA_r <= pwdata[MTT_ROUTE_A_LSB +: 3];
        routeB_r <= pwdata[MTT_ROUTE_B_LSB +: 3];
      end
      if (wrEn_m) begin
        enables_r <= pwdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // read latches and frame start capture
  // ----------------------------------------------------------------------
  // count low reads freeze the count high byte, and all of wrap with scope set; wrap low reads freeze wrap only with scope clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cntHiLatch_r  <= 8'h00;
      wrapHiLatch_r <= 16'h0000;
      wrapLoLatch_r <= 8'h00;
    end else if (rdCntLo) begin
      cntHiLatch_r <= cnt_r[15:8];
      if (scope_r) begin
        wrapLoLatch_r <= wrap_r[7:0];
        wrapHiLatch_r <= wrap_r[23:8];
      end
    end else if (rdWrp0 && !scope_r) begin
      wrapHiLatch_r <= wrap_r[23:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfdPrev_r <= 1'b0;
      cntCap_r  <= 16'h0000;
      wrapCap_r <= 24'h000000;
    end else begin
      sfdPrev_r <= sfdStatus;
      if (sfdStatus && !sfdPrev_r) begin
        cntCap_r  <= cnt_r;
        wrapCap_r <= wrap_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // flags, interrupt request and event outputs
  // ----------------------------------------------------------------------
  // written zeros clear; a hit in the same cycle still sets
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= 6'h00;
    end else if (wrFlags) begin
      flags_r <= (flags_r & pwdata[5:0]) | events;
    end else begin
      flags_r <= flags_r | events;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqReq    <= 1'b0;
      eventOutA <= 1'b0;
      eventOutB <= 1'b0;
    end else begin
      irqReq    <= |(flags_r & enables_r);
      eventOutA <= routeA_r != ROUTE_NONE && routeA_r < 3'h6
                   && events[routeA_r];
      eventOutB <= routeB_r != ROUTE_NONE && routeB_r < 3'h6
                   && events[routeB_r];
    end
  end

  // ----------------------------------------------------------------------
  // apb read path: answer one cycle after setup
  // ----------------------------------------------------------------------
  logic [15:0] cntView;
  logic [23:0] wrapView;
  logic [31:0] rdMux;
  logic        mapped;
  always_comb begin
    case (cntView_r)
      VIEW_COUNT:   cntView = {cntHiLatch_r, cnt_r[7:0]};
      VIEW_CAPTURE: cntView = cntCap_r;
      VIEW_PERIOD:  cntView = cntPer_r;
      VIEW_CMP_A:   cntView = cntCmpA_r;
      VIEW_CMP_B:   cntView = cntCmpB_r;
      default:      cntView = 16'h0000;
    endcase
    case (wrapView_r)
      VIEW_COUNT:   wrapView = {wrapHiLatch_r,
                                scope_r ? wrapLoLatch_r : wrap_r[7:0]};
      VIEW_CAPTURE: wrapView = wrapCap_r;
      VIEW_PERIOD:  wrapView = wrapPer_r;
      VIEW_CMP_A:   wrapView = wrapCmpA_r;
      VIEW_CMP_B:   wrapView = wrapCmpB_r;
      default:      wrapView = 24'h000000;
    endcase
  end

  always_comb begin
    rdMux  = 32'h0;
    mapped = 1'b1;
    case (paddr)
      MTT_OFF_CONTROL: begin
        rdMux[MTT_CTL_GO]    = go_r;
        rdMux[MTT_CTL_EDGE]  = edgeAligned_r;
        rdMux[MTT_CTL_STATE] = state_r == ST_RUN;
        rdMux[MTT_CTL_SCOPE] = scope_r;
      end
      MTT_OFF_VIEW_SEL: begin
        rdMux[MTT_VIEW_CNT_LSB +: 3] = cntView_r;
        rdMux[MTT_VIEW_WRP_LSB +: 3] = wrapView_r;
      end
      MTT_OFF_CNT_LOW:   rdMux[7:0] = cntView[7:0];
      MTT_OFF_CNT_HIGH:  rdMux[7:0] = cntView[15:8];
      MTT_OFF_WRAP_B0:   rdMux[7:0] = wrapView[7:0];
      MTT_OFF_WRAP_B1:   rdMux[7:0] = wrapView[15:8];
      MTT_OFF_WRAP_B2:   rdMux[7:0] = wrapView[23:16];
      MTT_OFF_FLAGS:     rdMux[5:0] = flags_r;
      MTT_OFF_ENABLES:   rdMux[5:0] = enables_r;
      MTT_OFF_EVT_ROUTE: begin
        rdMux[MTT_ROUTE_A_LSB +: 3] = routeA_r;
        rdMux[MTT_ROUTE_B_LSB +: 3] = routeB_r;
      end
      default: mapped = 1'b0;
    endcase
  end

  // a held read reflects state at setup; latches move at completion
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rdMux;
      end
    end
  end

endmodule : mtt_timer
`default_nettype wire

// File: mtt_timer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module mtt_timer_checker (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irqReq,
  input wire logic        eventOutA,
  input wire logic        eventOutB
);
  import mtt_pkg::*;
  logic [6:0] route_r;
  logic       goW_r;
  wire wrAcc = psel && penable && pwrite && pready;
  wire clrAcc = wrAcc && (paddr == MTT_OFF_FLAGS || paddr == MTT_OFF_ENABLES);
  // shadow copies, so checks need not trust the design's readback
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      route_r <= 7'h00;
      goW_r <= RST_GO;
    end else if (wrAcc && !pslverr) begin
      if (paddr == MTT_OFF_EVT_ROUTE) route_r <= pwdata[6:0];
      if (paddr == MTT_OFF_CONTROL) goW_r <= pwdata[MTT_CTL_GO];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_rst_quiet: assert property (disable iff (1'b0)
    !rst_b |-> !pready && !irqReq && !eventOutA) else $error("busy in reset");
  a_evt_a_pulse: assert property (eventOutA |=> !eventOutA)
    else $error("event a too long");
  a_evt_b_pulse: assert property (eventOutB |=> !eventOutB)
    else $error("event b too long");
  a_irq_clear: assert property ($fell(irqReq) |-> $past(clrAcc, 2))
    else $error("irq fell without write");
  a_unmapped_err: assert property (
    pready && paddr > MTT_OFF_EVT_ROUTE |-> pslverr) else $error("no error");
  a_route_a_none: assert property (
    route_r[2:0] == ROUTE_NONE && $past(route_r[2:0]) == ROUTE_NONE
    |-> !eventOutA) else $error("event a while off");
  a_route_b_none: assert property (
    route_r[6:4] == ROUTE_NONE && $past(route_r[6:4]) == ROUTE_NONE
    |-> !eventOutB) else $error("event b while off");
  a_go_readback: assert property (
    pready && !pwrite && !pslverr && paddr == MTT_OFF_CONTROL
    |-> prdata[MTT_CTL_GO] == goW_r) else $error("go readback");
endmodule : mtt_timer_checker
bind mtt_timer mtt_timer_checker u_chk (.sys_clk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irqReq,
  .eventOutA, .eventOutB);
`default_nettype wire

// File: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import mtt_pkg::*;
  logic sys_clk = 0, rst_b = 1, psel = 0, penable = 0, pwrite = 0;
  logic sfdStatus = 0, slowClkRise = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [23:0] sleepTimerValue = 24'h000000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, irqReq, eventOutA, eventOutB;
  int mismatches = 0, samplesChecked = 0, k;
  // rows: address, error expected, read data expected
  localparam logic [40:0] ROWS [4] = '{{MTT_OFF_CONTROL, 33'h2},
    {MTT_OFF_FLAGS, 33'h0}, {MTT_OFF_EVT_ROUTE, 33'h0}, {8'h28, 33'h100000000}};
  mtt_timer dut (.sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleepTimerValue, .slowClkRise, .sfdStatus,
    .irqReq, .eventOutA, .eventOutB);
  // clock, 8 ns period
  always #4 sys_clk = ~sys_clk;
  task chk(input logic [32:0] s, input logic [32:0] e);
    samplesChecked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one apb transfer; holds everything until pready is sampled
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk({err, rd}, {1'b0, e});
  endtask : rdc
  // one cycle pulse standing for a slow clock rising edge
  task slow_edge;
    slowClkRise <= 1'b1;
    @(posedge sys_clk);
    slowClkRise <= 1'b0;
  endtask : slow_edge
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // watchdog, far beyond the few hundred cycles the tests take
  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    // a real falling edge, so the async reset fires at time zero
    rst_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (ROWS[i]) begin
      apb(ROWS[i][40:33], 1'b0, 32'h0);
      chk({err, rd}, ROWS[i][32:0]);
    end
    $display("reset table done");
    wr(MTT_OFF_CNT_LOW, 32'h10);
    wr(MTT_OFF_CNT_HIGH, 32'h12);
    rdc(MTT_OFF_CNT_LOW, 32'h10);
    rdc(MTT_OFF_CNT_HIGH, 32'h12);
    sfdStatus <= 1'b1;
    wr(MTT_OFF_VIEW_SEL, 32'h11);
    rdc(MTT_OFF_CNT_LOW, 32'h10);
    rdc(MTT_OFF_CNT_HIGH, 32'h12);
    wr(MTT_OFF_VIEW_SEL, 32'h02);
    wr(MTT_OFF_CNT_LOW, 32'h20);
    wr(MTT_OFF_CNT_HIGH, 32'h0);
    wr(MTT_OFF_VIEW_SEL, 32'h00);
    // back to 0x0010 so the first wrap is 16 steps away
    wr(MTT_OFF_CNT_LOW, 32'h10);
    wr(MTT_OFF_CNT_HIGH, 32'h0);
    wr(MTT_OFF_ENABLES, 32'h1);
    wr(MTT_OFF_EVT_ROUTE, 32'h70);
    wr(MTT_OFF_CONTROL, 32'h1);
    // one edge to enter run, 16 steps to the period, one to register
    for (k = 0; k < 99 && eventOutA !== 1'b1; k++) @(posedge sys_clk);
    chk(33'(k), 33'd18);
    rdc(MTT_OFF_FLAGS, 32'h1);
    chk({32'h0, irqReq}, 33'h1);
    rdc(MTT_OFF_WRAP_B0, 32'h1);
    rdc(MTT_OFF_CONTROL, 32'h5);
    wr(MTT_OFF_FLAGS, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk({32'h0, irqReq}, 33'h0);
    wr(MTT_OFF_CONTROL, 32'h0);
    rdc(MTT_OFF_CONTROL, 32'h0);
    $display("run and stop done");
    // event a off, event b on period; aligned stop after a restart
    wr(MTT_OFF_EVT_ROUTE, 32'h07);
    wr(MTT_OFF_CONTROL, 32'h1);
    wr(MTT_OFF_CONTROL, 32'h2);
    rdc(MTT_OFF_CONTROL, 32'h6);
    sleepTimerValue <= 24'h000100;
    slow_edge;
    rdc(MTT_OFF_CONTROL, 32'h2);
    // period 0x1000, counter 0, wrap 5, then 16 sleep ticks later
    wr(MTT_OFF_VIEW_SEL, 32'h02);
    wr(MTT_OFF_CNT_LOW, 32'h00);
    wr(MTT_OFF_CNT_HIGH, 32'h10);
    wr(MTT_OFF_VIEW_SEL, 32'h00);
    wr(MTT_OFF_CNT_LOW, 32'h00);
    wr(MTT_OFF_CNT_HIGH, 32'h00);
    wr(MTT_OFF_WRAP_B0, 32'h05);
    wr(MTT_OFF_WRAP_B1, 32'h00);
    wr(MTT_OFF_WRAP_B2, 32'h00);
    rdc(MTT_OFF_WRAP_B0, 32'h05);
    wr(MTT_OFF_CONTROL, 32'h3);
    sleepTimerValue <= 24'h000110;
    rdc(MTT_OFF_CONTROL, 32'h3);
    slow_edge;
    rdc(MTT_OFF_CONTROL, 32'h3);
    repeat (86) @(posedge sys_clk);
    rdc(MTT_OFF_CONTROL, 32'h7);
    // 16 x 976.5625 + 0 + 86 = 15711 = 3 x 4096 + 0xd5f, wrap 5 + 3
    rdc(MTT_OFF_WRAP_B0, 32'h08);
    rdc(MTT_OFF_WRAP_B1, 32'h00);
    wr(MTT_OFF_CONTROL, 32'hb);
    apb(MTT_OFF_CNT_LOW, 1'b0, 32'h0);
    rdc(MTT_OFF_CNT_HIGH, 32'h0d);
    rdc(MTT_OFF_WRAP_B0, 32'h08);
    $display("aligned stop and start done");
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire
